// >>> src/cregf_pkg.sv
// constants, field positions and types shared by the core register block
// assumes one core clock; all offsets are direct special-register addresses
package cregf_pkg;

  // ***************************************
  // special register direct addresses
  // ***************************************
  localparam logic [7:0] SFR_STACK_TOP = 8'h81;
  localparam logic [7:0] SFR_DP_LOW = 8'h82;
  localparam logic [7:0] SFR_DP_HIGH = 8'h83;
  localparam logic [7:0] SFR_BUS_TIMING = 8'hC8;
  localparam logic [7:0] SFR_STATUS = 8'hD0;
  localparam logic [7:0] SFR_MAIN_OP = 8'hE0;
  localparam logic [7:0] SFR_SECOND_OP = 8'hF0;

  // ***************************************
  // reset values
  // ***************************************
  localparam logic [7:0] RST_STACK_TOP = 8'h07;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_INSTR_COUNTER = 16'h0000;

  // ***************************************
  // status word bit positions
  // ***************************************
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_F0 = 5;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_P = 0;

  // ***************************************
  // bus timing field, timing figures, queue depth and product limit
  // ***************************************
  localparam int BTC_DATA_WS_LSB = 0;
  localparam int BTC_DATA_WS_W = 3;
  localparam logic [2:0] WS_NONE = 3'h0;
  localparam logic [2:0] WS_HIGH_V = 3'h4;
  localparam logic [2:0] WS_LOW_V = 3'h5;
  localparam logic [1:0] MCYCLE_LAST = 2'h3;
  localparam logic [2:0] PFQ_DEPTH = 3'h6;
  localparam logic [7:0] MUL_MAX = 8'hFF;

  // ***************************************
  // operation codes and states
  // ***************************************
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ADD = 4'h1,
    OP_SUM_WITH_CARRY_INSTR = 4'h2,
    OP_DIFFERENCE_BORROW_INSTR = 4'h3,
    OP_MUL = 4'h4,
    OP_DIV = 4'h5,
    OP_RLC = 4'h6,
    OP_RRC = 4'h7,
    OP_CLEAR_SIGN_CHANGE_INSTR = 4'h8
  } cregf_op_t;

  typedef enum logic [1:0] {
    PF_IDLE = 2'b01,
    PF_WAIT = 2'b10
  } cregf_pf_state_t;

endpackage : cregf_pkg

// >>> src/cregf_pfq_if.sv
// carrier between the register block and its prefetch queue
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface cregf_pfq_if;
  logic take;
  logic flush;
  logic [15:0] flush_addr;
  logic [2:0] wait_states;
  logic [7:0] code_byte;
  logic code_valid;

  modport core (output take, output flush, output flush_addr, output wait_states,
                input code_byte, input code_valid);
  modport queue (input take, input flush, input flush_addr, input wait_states,
                 output code_byte, output code_valid);
endinterface : cregf_pfq_if

// >>> src/cregf_prefetch.sv
// six-byte code prefetch queue with fixed wait-state program memory reads
// assumes program memory data is valid on the last wait clock of a read
`timescale 1ns/1ps
module cregf_prefetch (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  cregf_pfq_if.queue pfq,
  input wire logic [7:0] i_pm_data,
  output logic o_pm_req,
  output logic [15:0] o_pm_addr
);
  import cregf_pkg::*;

  typedef struct packed {
    logic [5:0][7:0] q;
    logic [2:0] head;
    logic [2:0] count;
    logic [15:0] faddr;
    logic [2:0] wcnt;
    cregf_pf_state_t st;
  } cregf_pf_st_t;

  cregf_pf_st_t r;
  cregf_pf_st_t n;

  function automatic logic [2:0] wrap_add(input logic [2:0] a, input logic [2:0] b);
    logic [3:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, PFQ_DEPTH}) begin
      s = s - {1'b0, PFQ_DEPTH};
    end
    return s[2:0];
  endfunction : wrap_add

  // ***************************************
  // next state
  // ***************************************
  always_comb begin
    logic pop;
    logic push;
    logic [2:0] ws;
    pop = 1'b0;
    push = 1'b0;
    ws = (pfq.wait_states == WS_NONE) ? 3'h1 : pfq.wait_states;
    n = r;
    pop = pfq.take && (r.count != 3'h0);
    if (pop) begin
      n.head = wrap_add(r.head, 3'h1);
    end
    case (r.st)
      PF_IDLE: begin
        // only start a read when the byte has a slot; no dummy fetches
        if ((r.count - {2'b00, pop}) < PFQ_DEPTH) begin // RQ18
          n.st = PF_WAIT;
          n.wcnt = ws; // RQ17
        end
      end
      PF_WAIT: begin
        if (r.wcnt == 3'h1) begin
          push = 1'b1;
          n.q[wrap_add(r.head, r.count)] = i_pm_data;
          n.faddr = r.faddr + 16'h0001;
          // chain straight into the next read while the queue has room, with no idle clock between reads
          if ((r.count - {2'b00, pop} + 3'h1) < PFQ_DEPTH) begin // RQ16
            n.wcnt = ws;
          end else begin
            n.st = PF_IDLE;
          end
        end else begin
          n.wcnt = r.wcnt - 3'h1;
        end
      end
      default: begin
        n.st = PF_IDLE;
      end
    endcase
    n.count = r.count - {2'b00, pop} + {2'b00, push}; // RQ18
    // a branch drops queued bytes and any read in flight
    if (pfq.flush) begin
      n.count = 3'h0;
      n.head = 3'h0;
      n.faddr = pfq.flush_addr;
      n.st = PF_IDLE;
      n.wcnt = 3'h0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
      r.faddr <= RST_INSTR_COUNTER;
      r.st <= PF_IDLE;
    end else if (i_clk_en) begin
      r <= n;
    end
  end

  assign pfq.code_byte = r.q[r.head];
  assign pfq.code_valid = (r.count != 3'h0);
  assign o_pm_req = (r.st == PF_WAIT);
  assign o_pm_addr = r.faddr;

endmodule : cregf_prefetch

// >>> src/cregf_core.sv
// core register set, status flags, machine-cycle timing and code feed
// assumes the execution unit drives one operation at most per clock and
// uses the stack, bank and pointer outputs for its internal data accesses
`timescale 1ns/1ps

// Functional notes
// RQ1 - stack top resets to 07h, first push 08h
// RQ2 - push increments first, pop decrements after
// RQ3 - data pointer is two bytes, sixteen bits
// RQ4 - instruction counter sixteen bits, resets to zero
// RQ5 - main operand pairs with second for multiply/divide
// RQ6 - four banks of eight in first 32 bytes
// RQ7 - bank select bits pick the active bank
// RQ8 - bank zero active after reset
// RQ9 - carry from add/borrow, rotates, else cleared
// RQ10 - half carry from low nibble, else cleared
// RQ11 - sign-change on overflow, big product, zero divisor
// RQ12 - clear instruction always clears sign-change flag
// RQ13 - parity follows odd ones in main operand
// RQ14 - user flag changed only by software writes
// RQ15 - machine cycle is four clocks
// RQ16 - prefetch keeps fetching, no idle bus cycles
// RQ17 - four or five wait states, data override
// RQ18 - queue holds six bytes, fetches only needed
module cregf_core (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic i_low_voltage,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire cregf_pkg::cregf_op_t i_alu_op,
  input wire logic [7:0] i_alu_src,
  input wire logic i_push,
  input wire logic i_pop,
  output logic [7:0] o_stack_top,
  input wire logic [2:0] i_wreg_idx,
  output logic [7:0] o_wreg_addr,
  input wire logic i_data_pointer_load,
  input wire logic [15:0] i_data_pointer_value,
  output logic [15:0] o_data_pointer,
  input wire logic i_branch,
  input wire logic [15:0] i_branch_addr,
  input wire logic i_code_take,
  output logic [7:0] o_code_byte,
  output logic o_code_valid,
  output logic [15:0] o_instr_counter,
  output logic [7:0] o_main_operand,
  output logic [7:0] o_second_operand,
  output logic [7:0] o_status_word,
  output logic o_mcycle_pulse,
  output logic [2:0] o_data_wait_states,
  input wire logic [7:0] i_pm_data,
  output logic o_pm_req,
  output logic [15:0] o_pm_addr
);
  import cregf_pkg::*;

  typedef struct packed {
    logic [7:0] sp;
    logic [7:0] data_pointer_low;
    logic [7:0] data_pointer_high;
    logic [7:0] instr_counter_low;
    logic [7:0] instr_counter_high;
    logic [7:0] acc;
    logic [7:0] b;
    logic cy;
    logic ac;
    logic f0;
    logic rs1;
    logic rs0;
    logic ov;
    logic [7:0] btc;
    logic [1:0] mcnt;
    logic [7:0] rdata;
  } cregf_core_st_t;

  cregf_core_st_t r;
  cregf_core_st_t n;
  cregf_pfq_if pfq ();

  logic parity;
  logic [7:0] psw_view;
  logic [2:0] prog_ws;
  logic [2:0] data_ws_field;

  // ***************************************
  // prefetch queue
  // ***************************************
  cregf_prefetch u_prefetch (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .pfq(pfq.queue),
    .i_pm_data(i_pm_data),
    .o_pm_req(o_pm_req),
    .o_pm_addr(o_pm_addr)
  );

  // lower supply needs the slower memory timing
  assign prog_ws = i_low_voltage ? WS_LOW_V : WS_HIGH_V; // RQ17
  assign data_ws_field = r.btc[BTC_DATA_WS_LSB +: BTC_DATA_WS_W];
  assign pfq.wait_states = prog_ws;
  assign pfq.take = i_code_take;
  assign pfq.flush = i_branch;
  assign pfq.flush_addr = i_branch_addr;

  // ***************************************
  // status word view
  // ***************************************
  // parity is a live function of the main operand, never stored
  assign parity = ^r.acc; // RQ13

  always_comb begin
    psw_view = RST_BYTE;
    psw_view[PSW_CY] = r.cy;
    psw_view[PSW_AC] = r.ac;
    psw_view[PSW_F0] = r.f0;
    psw_view[PSW_RS1] = r.rs1;
    psw_view[PSW_RS0] = r.rs0;
    psw_view[PSW_OV] = r.ov;
    psw_view[PSW_P] = parity;
  end

  // ***************************************
  // next state
  // ***************************************
  always_comb begin
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [15:0] prod;
    logic [7:0] res;
    logic cin;
    sum9 = 9'h000;
    nib5 = 5'h00;
    prod = 16'h0000;
    res = 8'h00;
    cin = 1'b0;
    n = r;

    // machine cycle of four clocks
    n.mcnt = (r.mcnt == MCYCLE_LAST) ? 2'h0 : r.mcnt + 2'h1; // RQ15

    // ***************************************
    // register bus
    // ***************************************
    // software access comes first; the execution unit overrides below
    if (i_sfr_wr) begin
      case (i_sfr_addr)
        SFR_STACK_TOP: begin
          n.sp = i_sfr_wdata;
        end
        SFR_DP_LOW: begin
          n.data_pointer_low = i_sfr_wdata; // RQ3
        end
        SFR_DP_HIGH: begin
          n.data_pointer_high = i_sfr_wdata; // RQ3
        end
        SFR_BUS_TIMING: begin
          n.btc = i_sfr_wdata; // RQ17
        end
        SFR_MAIN_OP: begin
          n.acc = i_sfr_wdata;
        end
        SFR_SECOND_OP: begin
          n.b = i_sfr_wdata;
        end
        SFR_STATUS: begin
          n.cy = i_sfr_wdata[PSW_CY];
          n.ac = i_sfr_wdata[PSW_AC];
          n.f0 = i_sfr_wdata[PSW_F0]; // RQ14
          n.rs1 = i_sfr_wdata[PSW_RS1]; // RQ7
          n.rs0 = i_sfr_wdata[PSW_RS0]; // RQ7
          n.ov = i_sfr_wdata[PSW_OV];
        end
        default: begin
          n.rdata = r.rdata;
        end
      endcase
    end

    if (i_sfr_rd) begin
      case (i_sfr_addr)
        SFR_STACK_TOP: begin
          n.rdata = r.sp;
        end
        SFR_DP_LOW: begin
          n.rdata = r.data_pointer_low;
        end
        SFR_DP_HIGH: begin
          n.rdata = r.data_pointer_high;
        end
        SFR_BUS_TIMING: begin
          n.rdata = r.btc;
        end
        SFR_MAIN_OP: begin
          n.rdata = r.acc;
        end
        SFR_SECOND_OP: begin
          n.rdata = r.b;
        end
        SFR_STATUS: begin
          n.rdata = psw_view;
        end
        default: begin
          n.rdata = RST_BYTE;
        end
      endcase
    end

    // ***************************************
    // stack, pointer and counter
    // ***************************************
    // stack: address is bumped before the write, dropped after the read
    // a push and a pop together cancel out
    if (i_push && !i_pop) begin
      n.sp = r.sp + 8'h01; // RQ2
    end else if (i_pop && !i_push) begin
      n.sp = r.sp - 8'h01; // RQ2
    end

    // a whole-pointer load beats byte writes in the same cycle
    if (i_data_pointer_load) begin
      n.data_pointer_low = i_data_pointer_value[7:0]; // RQ3
      n.data_pointer_high = i_data_pointer_value[15:8]; // RQ3
    end

    // instruction counter tracks the next code byte handed out
    if (i_branch) begin
      n.instr_counter_low = i_branch_addr[7:0]; // RQ4
      n.instr_counter_high = i_branch_addr[15:8]; // RQ4
    end else if (i_code_take && pfq.code_valid) begin
      {n.instr_counter_high, n.instr_counter_low} = {r.instr_counter_high, r.instr_counter_low} + 16'h0001; // RQ4
    end

    // ***************************************
    // arithmetic
    // ***************************************
    // arithmetic and flag updates; the user flag is never touched here
    case (i_alu_op)
      OP_ADD, OP_SUM_WITH_CARRY_INSTR: begin
        cin = (i_alu_op == OP_SUM_WITH_CARRY_INSTR) ? r.cy : 1'b0;
        sum9 = {1'b0, r.acc} + {1'b0, i_alu_src} + {8'h00, cin};
        nib5 = {1'b0, r.acc[3:0]} + {1'b0, i_alu_src[3:0]} + {4'h0, cin};
        res = sum9[7:0];
        n.acc = res;
        n.cy = sum9[8]; // RQ9
        n.ac = nib5[4]; // RQ10
        n.ov = (r.acc[7] == i_alu_src[7]) && (res[7] != r.acc[7]); // RQ11
      end
      OP_DIFFERENCE_BORROW_INSTR: begin
        // borrow shows up as the ninth bit of the wrapped difference
        sum9 = {1'b0, r.acc} - {1'b0, i_alu_src} - {8'h00, r.cy};
        nib5 = {1'b0, r.acc[3:0]} - {1'b0, i_alu_src[3:0]} - {4'h0, r.cy};
        res = sum9[7:0];
        n.acc = res;
        n.cy = sum9[8]; // RQ9
        n.ac = nib5[4]; // RQ10
        n.ov = (r.acc[7] != i_alu_src[7]) && (res[7] != r.acc[7]); // RQ11
      end
      OP_MUL: begin
        // 16-bit product split across the operand pair
        prod = {8'h00, r.acc} * {8'h00, r.b}; // RQ5
        n.acc = prod[7:0]; // RQ5
        n.b = prod[15:8]; // RQ5
        n.cy = 1'b0; // RQ9
        n.ac = 1'b0; // RQ10
        n.ov = (prod > {8'h00, MUL_MAX}); // RQ11
      end
      OP_DIV: begin
        n.cy = 1'b0; // RQ9
        n.ac = 1'b0; // RQ10
        if (r.b == RST_BYTE) begin
          // operands left as they were on a zero divisor
          n.ov = 1'b1; // RQ11
        end else begin
          n.acc = r.acc / r.b; // RQ5
          n.b = r.acc % r.b; // RQ5
          n.ov = 1'b0; // RQ11
        end
      end
      OP_RLC: begin
        // carry enters at bit zero, bit seven leaves into carry
        {n.cy, n.acc} = {r.acc, r.cy}; // RQ9
      end
      OP_RRC: begin
        // carry enters at bit seven, bit zero leaves into carry
        {n.acc, n.cy} = {r.cy, r.acc}; // RQ9
      end
      OP_CLEAR_SIGN_CHANGE_INSTR: begin
        n.ov = 1'b0; // RQ12
      end
      default: begin
        n.ov = n.ov;
      end
    endcase
  end

  // ***************************************
  // state register
  // ***************************************
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
      r.sp <= RST_STACK_TOP; // RQ1
      r.data_pointer_low <= RST_BYTE;
      r.data_pointer_high <= RST_BYTE;
      {r.instr_counter_high, r.instr_counter_low} <= RST_INSTR_COUNTER; // RQ4
      r.rs1 <= 1'b0; // RQ8
      r.rs0 <= 1'b0; // RQ8
    end else if (i_clk_en) begin
      // a low enable freezes every field, the machine cycle too
      r <= n;
    end
  end

  // ***************************************
  // outputs
  // ***************************************
  // bank base is bank number times eight inside the first 32 bytes
  assign o_wreg_addr = {3'b000, r.rs1, r.rs0, i_wreg_idx}; // RQ6
  assign o_stack_top = r.sp;
  assign o_data_pointer = {r.data_pointer_high, r.data_pointer_low};
  assign o_instr_counter = {r.instr_counter_high, r.instr_counter_low};
  assign o_main_operand = r.acc;
  assign o_second_operand = r.b;
  assign o_status_word = psw_view;
  assign o_sfr_rdata = r.rdata;

  // ***************************************
  // timing and code feed
  // ***************************************
  assign o_mcycle_pulse = (r.mcnt == MCYCLE_LAST) && i_clk_en; // RQ15
  // a zero data field means data accesses follow the program timing
  assign o_data_wait_states = (data_ws_field == WS_NONE) ? prog_ws : data_ws_field; // RQ17
  assign o_code_byte = pfq.code_byte;
  assign o_code_valid = pfq.code_valid;

endmodule : cregf_core

// >>> test/cregf_pmem.sv
// program memory model for the code feed of the core register block
// assumes the block samples data on the last wait clock of each read
`timescale 1ns/1ps
module cregf_pmem (
  input wire logic i_sys_clk,
  input wire logic i_req,
  input wire logic [15:0] i_addr,
  output logic [7:0] o_data
);
  logic [7:0] junk_r;
  // *******************
  // read data
  // *******************
  initial begin
    junk_r = 8'hA5;
  end
  // idle bus toggles so a late sample never sees the last byte
  always @(posedge i_sys_clk) begin
    junk_r <= ~junk_r;
  end
  assign o_data = i_req ? (i_addr[7:0] ^ 8'h5A) : junk_r;
endmodule : cregf_pmem

// >>> test/cregf_core_chk.sv
// port assertions for the core register block
// assumes a bind from the bench top and a single clock domain
`timescale 1ns/1ps
module cregf_core_chk (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic i_low_voltage,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire cregf_pkg::cregf_op_t i_alu_op,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [7:0] o_stack_top,
  input wire logic [2:0] i_wreg_idx,
  input wire logic [7:0] o_wreg_addr,
  input wire logic i_branch,
  input wire logic o_pm_req,
  input wire logic [15:0] o_pm_addr,
  input wire logic [7:0] o_main_operand,
  input wire logic [7:0] o_second_operand,
  input wire logic [7:0] o_status_word,
  input wire logic o_mcycle_pulse
);
  import cregf_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // *******************
  // properties
  // *******************
  property p_parity;
    o_status_word[PSW_P] == ^o_main_operand;
  endproperty
  a_parity: assert property (p_parity) else $error("parity bit wrong");
  property p_bank;
    o_wreg_addr == {3'b000, o_status_word[PSW_RS1], o_status_word[PSW_RS0], i_wreg_idx};
  endproperty
  a_bank: assert property (p_bank) else $error("bank address wrong");
  property p_push;
    i_clk_en && i_push && !i_pop |=> o_stack_top == $past(o_stack_top) + 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("push did not step up");
  property p_clear_sign_change_instr;
    i_clk_en && i_alu_op == OP_CLEAR_SIGN_CHANGE_INSTR |=> !o_status_word[PSW_OV];
  endproperty
  a_clear_sign_change_instr: assert property (p_clear_sign_change_instr) else $error("sign change not cleared");
  property p_mcycle;
    o_mcycle_pulse ##1 i_clk_en [*4] |-> o_mcycle_pulse;
  endproperty
  a_mcycle: assert property (p_mcycle) else $error("machine cycle not four");
  // read start to address step spans the four wait clocks
  property p_ws4;
    $rose(o_pm_req) && i_clk_en && !i_branch && !i_low_voltage
      ##1 (i_clk_en && !i_branch && !i_low_voltage) [*3]
      |=> o_pm_addr == $past(o_pm_addr, 4) + 16'h0001;
  endproperty
  a_ws4: assert property (p_ws4) else $error("read length wrong");
  property p_mul;
    i_clk_en && i_alu_op == OP_MUL |=>
      {o_second_operand, o_main_operand} == $past(o_second_operand) * $past(o_main_operand)
      && o_status_word[PSW_OV] == (o_second_operand != 8'h00);
  endproperty
  a_mul: assert property (p_mul) else $error("product wrong");
  property p_user;
    !(i_clk_en && i_sfr_wr && i_sfr_addr == SFR_STATUS) |=> $stable(o_status_word[PSW_F0]);
  endproperty
  a_user: assert property (p_user) else $error("user flag moved");
  c_mul: cover property (i_clk_en && i_alu_op == OP_MUL);
  c_branch: cover property (i_clk_en && i_branch);
  c_read: cover property ($rose(o_pm_req));
endmodule : cregf_core_chk

// >>> test/cregf_core_tb.sv
// self-checking bench for the core register block
// assumes the program memory model answers every read
`timescale 1ns/1ps
module cregf_core_tb;
  import cregf_pkg::*;
  logic i_sys_clk, i_resetn, i_clk_en, i_low_voltage, i_sfr_wr, i_sfr_rd, i_push, i_pop;
  logic i_data_pointer_load, i_branch, i_code_take, o_code_valid, o_mcycle_pulse, o_pm_req;
  logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, i_alu_src, o_stack_top, o_wreg_addr;
  logic [7:0] o_code_byte, o_main_operand, o_second_operand, o_status_word, i_pm_data;
  logic [15:0] i_data_pointer_value, o_data_pointer, i_branch_addr, o_instr_counter, o_pm_addr;
  logic [2:0] i_wreg_idx, o_data_wait_states;
  cregf_op_t i_alu_op;
  int n_fail = 0;
  int n_compared = 0;
  cregf_op_t ops[10] = '{OP_ADD, OP_ADD, OP_SUM_WITH_CARRY_INSTR, OP_DIFFERENCE_BORROW_INSTR, OP_MUL, OP_RLC, OP_RRC, OP_DIV,
                         OP_DIV, OP_CLEAR_SIGN_CHANGE_INSTR};
  logic [7:0] srcs[10] = '{8'h01, 8'h80, 8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h00};
  // main, second, status after each operation
  logic [23:0] exps[10] = '{24'h80_0245, 24'h00_0284, 24'h02_0201, 24'hFF_02C0, 24'hFE_0105,
                            24'hFC_0184, 24'hFE_0105, 24'hFE_0001, 24'hFE_0005, 24'hFE_0001};

  cregf_core dut (.*);
  cregf_pmem u_pmem (.i_sys_clk, .i_req(o_pm_req), .i_addr(o_pm_addr), .o_data(i_pm_data));

  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  // *******************
  // shared tasks
  // *******************
  task end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  task chk(input string n, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_sfr_wr <= 1'b0;
    #1;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_sfr_addr <= a;
    i_sfr_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_sfr_rd <= 1'b0;
    #1 chk("read data", 24'(e), 24'(o_sfr_rdata));
  endtask : rd

  task stk(input logic p, input logic q, input logic en, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_push <= p;
    i_pop <= q;
    i_clk_en <= en;
    @(posedge i_sys_clk);
    i_push <= 1'b0;
    i_pop <= 1'b0;
    i_clk_en <= 1'b1;
    #1 chk("stack top", 24'(e), 24'(o_stack_top));
  endtask : stk

  // *******************
  // scenarios
  // *******************
  task t_sfr;
    wr(SFR_STACK_TOP, 8'h20);
    rd(SFR_STACK_TOP, 8'h20);
    wr(SFR_DP_LOW, 8'h34);
    wr(SFR_DP_HIGH, 8'h12);
    chk("pointer", 24'h00_1234, 24'(o_data_pointer));
    @(posedge i_sys_clk);
    i_data_pointer_value <= 16'hABCD;
    i_data_pointer_load <= 1'b1;
    @(posedge i_sys_clk);
    i_data_pointer_load <= 1'b0;
    #1 chk("pointer load", 24'h00_ABCD, 24'(o_data_pointer));
    rd(8'h80, 8'h00);
    wr(SFR_BUS_TIMING, 8'h02);
    chk("data waits", 24'h00_0002, 24'(o_data_wait_states));
    wr(SFR_BUS_TIMING, 8'h00);
    chk("data waits", 24'h00_0004, 24'(o_data_wait_states));
  endtask : t_sfr

  task t_stack;
    stk(1'b1, 1'b0, 1'b1, 8'h21);
    stk(1'b0, 1'b1, 1'b1, 8'h20);
    stk(1'b1, 1'b1, 1'b1, 8'h20);
    // frozen clock enable must hold state
    stk(1'b1, 1'b0, 1'b0, 8'h20);
  endtask : t_stack

  task t_mcycle;
    int c;
    c = 0;
    repeat (8) begin
      @(posedge i_sys_clk);
      #1;
      if (o_mcycle_pulse === 1'b1) c++;
    end
    chk("mcycle pulses", 24'h00_0002, 24'(c));
  endtask : t_mcycle

  task t_bank;
    for (int b = 0; b < 4; b++) begin
      wr(SFR_STATUS, 8'h20 | 8'(b << 3));
      chk("bank addr", 24'(b * 8 + 5), 24'(o_wreg_addr));
      chk("user flag", 24'h00_0001, 24'(o_status_word[PSW_F0]));
    end
  endtask : t_bank

  task t_alu;
    wr(SFR_MAIN_OP, 8'h7F);
    wr(SFR_SECOND_OP, 8'h02);
    wr(SFR_STATUS, 8'h00);
    for (int k = 0; k < 10; k++) begin
      @(posedge i_sys_clk);
      i_alu_op <= ops[k];
      i_alu_src <= srcs[k];
      @(posedge i_sys_clk);
      i_alu_op <= OP_NONE;
      #1 chk("alu result", exps[k], {o_main_operand, o_second_operand, o_status_word});
    end
  endtask : t_alu

  task t_fetch(input logic lv);
    int n;
    @(posedge i_sys_clk);
    i_low_voltage <= lv;
    i_branch_addr <= 16'h0100;
    i_branch <= 1'b1;
    @(posedge i_sys_clk);
    i_branch <= 1'b0;
    n = 1;
    #1;
    while (o_code_valid !== 1'b1 && n < 30) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    chk("first byte delay", 24'(lv ? 7 : 6), 24'(n));
    chk("counter", 24'h00_0100, 24'(o_instr_counter));
    chk("data waits", 24'(lv ? 5 : 4), 24'(o_data_wait_states));
    repeat (60) @(posedge i_sys_clk);
    #1 chk("full stops reads", 24'h00_0000, 24'(o_pm_req));
    @(posedge i_sys_clk);
    i_code_take <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      #1 chk("code byte", 24'(8'(k) ^ 8'h5A), 24'(o_code_byte));
      @(posedge i_sys_clk);
    end
    i_code_take <= 1'b0;
    #1 chk("counter", 24'h00_0106, 24'(o_instr_counter));
  endtask : t_fetch

  initial begin
    i_resetn = 1'b0;
    {i_clk_en, i_low_voltage, i_sfr_wr, i_sfr_rd, i_push, i_pop} = 6'h00;
    {i_data_pointer_load, i_branch, i_code_take} = 3'h0;
    {i_sfr_addr, i_sfr_wdata, i_alu_src} = 24'h00_0000;
    {i_data_pointer_value, i_branch_addr} = 32'h0000_0000;
    i_wreg_idx = 3'h5;
    i_alu_op = OP_NONE;
    repeat (16) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    i_clk_en <= 1'b1;
    #1 chk("stack reset", 24'h00_0007, 24'(o_stack_top));
    chk("counter reset", 24'h00_0000, 24'(o_instr_counter));
    chk("bank reset", 24'h00_0005, 24'(o_wreg_addr));
    t_sfr();
    t_stack();
    t_mcycle();
    t_bank();
    t_alu();
    t_fetch(1'b0);
    t_fetch(1'b1);
    end_sim();
  end

  initial begin
    #20us;
    n_fail++;
    $display("MISMATCH watchdog expected done seen hang");
    end_sim();
  end
endmodule : cregf_core_tb

bind cregf_core cregf_core_chk u_chk (.i_sys_clk, .i_resetn, .i_clk_en, .i_low_voltage,
  .i_sfr_addr, .i_sfr_wr, .i_alu_op, .i_push, .i_pop, .o_stack_top, .i_wreg_idx, .o_wreg_addr,
  .i_branch, .o_pm_req, .o_pm_addr, .o_main_operand, .o_second_operand, .o_status_word,
  .o_mcycle_pulse);
